// ==== rtl/tfm_monitor.sv ====
// fault monitor for die/thermistor temperature, config-channel overvoltage and cable supply
//
// Notes on behaviour
// - debounced die warning sends temperature Alert
// - debounced die over-temperature raises fault, protection
// - Alert of earlier over-temperature after new contract
// - thermistor package: either over-temperature disconnects, VBUS off
// - thermistor package: warning only from thermistor
// - debounced CC1 or CC2 overvoltage raises fault
// - switch VCONN on for e-marker discovery
// - debounced VCONN overcurrent: VCONN off, abort discovery
// - after abort advertise 3 A, messaging continues
// - no Alert for VCONN overcurrent; Status bit instead
// - protection: pull-up off, switch open, restart 5 V
`timescale 1ns/1ps
module tfm_monitor
    import tfm_pkg::*;
#(
    parameter int unsigned THERMAL_DEB_CYC = tfm_pkg::THERMAL_DEBOUNCE_CYC,
    parameter int unsigned CC_DEB_CYC = tfm_pkg::CONFIG_CHANNEL_DEBOUNCE_CYC,
    parameter int unsigned VCONN_DEB_CYC = tfm_pkg::CABLE_SUPPLY_DEBOUNCE_CYC,
    parameter longint unsigned RESTART_CYC = tfm_pkg::AUTO_RESTART_CYC
) (
    input wire logic CORE_CLK_I,
    input wire logic SYS_RST_I,
    // package strap: high when the thermistor pin is bonded
    input wire logic THERMISTOR_PKG_I,
    // comparator outputs from analog, asynchronous to the core clock
    input wire logic DIE_WARN_I,
    input wire logic DIE_OTP_I,
    input wire logic THERM_WARN_I,
    input wire logic THERM_OTP_I,
    input wire logic CC1_OVER_I,
    input wire logic CC2_OVER_I,
    input wire logic VCONN_OVER_I,
    // from the policy engine, same clock
    input wire logic ATTACH_I,
    input wire logic CONTRACT_DONE_I,
    input wire logic ALERT_TAKEN_I,
    // outputs
    output logic ALERT_WARN_O,
    output logic ALERT_OTP_O,
    output logic DIE_OTP_FAULT_O,
    output logic THERM_OTP_FAULT_O,
    output logic CONFIG_CHANNEL_OVERVOLTAGE_FAULT_FAULT_O,
    output logic CABLE_SUPPLY_OVERCURRENT_FAULT_FAULT_O,
    output logic CC_PULLUP_EN_O,
    output logic LOAD_SWITCH_EN_O,
    output logic RESTART_O,
    output logic [8:0] RESTART_VOLTAGE_O,
    output logic VCONN_EN_O,
    output logic DISCOVERY_ABORT_O,
    output logic [8:0] MAX_CURRENT_O,
    output logic STATUS_CABLE_LIMIT_O
);
    localparam int unsigned NIN = 7;
    localparam int unsigned RW = $clog2(RESTART_CYC + 1);
    // refuse counts that leave nothing to count
    if (THERMAL_DEB_CYC < 1 || CC_DEB_CYC < 1 || VCONN_DEB_CYC < 1 || RESTART_CYC < 1) begin : g_bad
        $error("tfm_monitor: all cycle counts must be at least 1");
    end

    // raw inputs gathered for the synchronisers
    logic [NIN-1:0] raw;
    assign raw = {VCONN_OVER_I, CC2_OVER_I, CC1_OVER_I, THERM_OTP_I, THERM_WARN_I, DIE_OTP_I, DIE_WARN_I};
    // three-stage synchroniser per input, filtered level
    logic [NIN-1:0] s1_q;
    logic [NIN-1:0] s2_q;
    logic [NIN-1:0] s3_q;
    logic [NIN-1:0] lvl_q;

    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_sync
            // first stage feeds only the second; level changes once stages two and three agree
            always_ff @(posedge CORE_CLK_I) begin
                if (SYS_RST_I) begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                    s3_q[gi] <= 1'b0;
                    lvl_q[gi] <= 1'b0;
                end else begin
                    s1_q[gi] <= raw[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi]) begin
                        lvl_q[gi] <= s3_q[gi];
                    end
                end
            end
        end
    endgenerate

    // strap caught by the clock while reset is held
    logic thermistor_pkg_q;
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            thermistor_pkg_q <= THERMISTOR_PKG_I;
        end
    end

    // debounced conditions
    logic die_warn_hit;
    logic die_otp_hit;
    logic therm_warn_hit;
    logic therm_otp_hit;
    logic cc1_hit;
    logic cc2_hit;
    logic vconn_hit;

    // one counter per monitored condition; each restarts on drop-out
    // a one-cycle glitch is already swallowed by the filter, so only real drop-outs restart a count
    tfm_debounce #(.COUNT(THERMAL_DEB_CYC)) u_deb_die_warn (
        .clk_i(CORE_CLK_I),
        .rst_i(SYS_RST_I),
        .cond_i(lvl_q[0]),
        .hit_o(die_warn_hit)
    );
    tfm_debounce #(.COUNT(THERMAL_DEB_CYC)) u_deb_die_otp (
        .clk_i(CORE_CLK_I),
        .rst_i(SYS_RST_I),
        .cond_i(lvl_q[1]),
        .hit_o(die_otp_hit)
    );
    // thermistor counters held at zero on the package without the pin
    tfm_debounce #(.COUNT(THERMAL_DEB_CYC)) u_deb_therm_warn (
        .clk_i(CORE_CLK_I),
        .rst_i(SYS_RST_I),
        .cond_i(lvl_q[2] & thermistor_pkg_q),
        .hit_o(therm_warn_hit)
    );
    tfm_debounce #(.COUNT(THERMAL_DEB_CYC)) u_deb_therm_otp (
        .clk_i(CORE_CLK_I),
        .rst_i(SYS_RST_I),
        .cond_i(lvl_q[3] & thermistor_pkg_q),
        .hit_o(therm_otp_hit)
    );
    // each channel has its own comparator and its own counter
    tfm_debounce #(.COUNT(CC_DEB_CYC)) u_deb_cc1 (
        .clk_i(CORE_CLK_I),
        .rst_i(SYS_RST_I),
        .cond_i(lvl_q[4]),
        .hit_o(cc1_hit)
    );
    tfm_debounce #(.COUNT(CC_DEB_CYC)) u_deb_cc2 (
        .clk_i(CORE_CLK_I),
        .rst_i(SYS_RST_I),
        .cond_i(lvl_q[5]),
        .hit_o(cc2_hit)
    );
    // cable supply only counts while it is actually sourced
    // limitation: a surge while the supply is off is never seen, which is fine as nothing is sourced
    tfm_debounce #(.COUNT(VCONN_DEB_CYC)) u_deb_vconn (
        .clk_i(CORE_CLK_I),
        .rst_i(SYS_RST_I),
        .cond_i(lvl_q[6] & VCONN_EN_O),
        .hit_o(vconn_hit)
    );

    // combined fault conditions
    logic warn_src;
    logic otp_now;
    logic cc_now;
    logic any_fault;
    // warning source depends on package: thermistor only where bonded
    assign warn_src = thermistor_pkg_q ? therm_warn_hit : die_warn_hit;
    // die always monitored; thermistor adds its own fault
    assign otp_now = die_otp_hit | therm_otp_hit;
    assign cc_now = cc1_hit | cc2_hit;
    // cable supply overcurrent is not part of the protection sequence
    assign any_fault = otp_now | cc_now;

    // protection sequence state
    tfm_prot_e state_q;
    logic [RW-1:0] restart_cnt_q;

    // fault, hold while present, then auto-restart delay
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            state_q <= TFM_RUN;
            restart_cnt_q <= '0;
        end else begin
            unique case (state_q)
                TFM_RUN: begin
                    if (any_fault) begin
                        state_q <= TFM_FAULT;
                    end
                end
                TFM_FAULT: begin
                    // keep monitoring; delay starts when the fault is gone
                    restart_cnt_q <= '0;
                    if (!any_fault) begin
                        state_q <= TFM_RESTART;
                    end
                end
                TFM_RESTART: begin
                    if (any_fault) begin
                        state_q <= TFM_FAULT;
                    end else if (restart_cnt_q == RW'(RESTART_CYC - 1)) begin
                        state_q <= TFM_RUN;
                    end else begin
                        restart_cnt_q <= restart_cnt_q + RW'(1);
                    end
                end
            endcase
        end
    end

    // connection controls: pull-up and load switch off outside run
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            CC_PULLUP_EN_O <= 1'b1;
            LOAD_SWITCH_EN_O <= 1'b1;
            RESTART_O <= 1'b0;
            RESTART_VOLTAGE_O <= RESTART_VOLTAGE_5V;
        end else begin
            CC_PULLUP_EN_O <= (state_q == TFM_RUN) && !any_fault;
            LOAD_SWITCH_EN_O <= (state_q == TFM_RUN) && !any_fault;
            RESTART_O <= (state_q == TFM_RESTART) && !any_fault &&
                         (restart_cnt_q == RW'(RESTART_CYC - 1));
            RESTART_VOLTAGE_O <= RESTART_VOLTAGE_5V;
        end
    end

    // fault flags: level outputs showing the debounced condition
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            DIE_OTP_FAULT_O <= 1'b0;
            THERM_OTP_FAULT_O <= 1'b0;
            CONFIG_CHANNEL_OVERVOLTAGE_FAULT_FAULT_O <= 1'b0;
        end else begin
            DIE_OTP_FAULT_O <= die_otp_hit;
            THERM_OTP_FAULT_O <= therm_otp_hit;
            CONFIG_CHANNEL_OVERVOLTAGE_FAULT_FAULT_O <= cc_now;
        end
    end

    // warning alert: request raised on the rising edge of the debounced warning
    logic warn_prev_q;
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            warn_prev_q <= 1'b0;
            ALERT_WARN_O <= 1'b0;
        end else begin
            warn_prev_q <= warn_src;
            // a new warning wins over the acknowledge in the same cycle
            if (warn_src && !warn_prev_q) begin
                ALERT_WARN_O <= 1'b1;
            end else if (ALERT_TAKEN_I) begin
                ALERT_WARN_O <= 1'b0;
            end
        end
    end

    // over-temperature history: kept until reported after the next contract
    logic otp_hist_q;
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            otp_hist_q <= 1'b0;
            ALERT_OTP_O <= 1'b0;
        end else begin
            if (otp_now) begin
                otp_hist_q <= 1'b1;
            end else if (CONTRACT_DONE_I && otp_hist_q && state_q == TFM_RUN) begin
                otp_hist_q <= 1'b0;
            end
            // history reported only once a fresh contract is up
            if (CONTRACT_DONE_I && otp_hist_q && state_q == TFM_RUN && !otp_now) begin
                ALERT_OTP_O <= 1'b1;
            end else if (ALERT_TAKEN_I) begin
                ALERT_OTP_O <= 1'b0;
            end
        end
    end

    // cable supply: on while attached for discovery, off after an overcurrent until the next detach
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            VCONN_EN_O <= 1'b0;
            CABLE_SUPPLY_OVERCURRENT_FAULT_FAULT_O <= 1'b0;
            DISCOVERY_ABORT_O <= 1'b0;
        end else begin
            DISCOVERY_ABORT_O <= 1'b0;
            // the overcurrent set wins over a detach while vconn_hit is high, one cycle past the cut; the first detached cycle after that clears it
            if (vconn_hit) begin
                VCONN_EN_O <= 1'b0;
                CABLE_SUPPLY_OVERCURRENT_FAULT_FAULT_O <= 1'b1;
                DISCOVERY_ABORT_O <= 1'b1;
            end else if (!ATTACH_I) begin
                // detach clears the latch so the next cable gets a fresh attempt
                VCONN_EN_O <= 1'b0;
                CABLE_SUPPLY_OVERCURRENT_FAULT_FAULT_O <= 1'b0;
            end else if (!CABLE_SUPPLY_OVERCURRENT_FAULT_FAULT_O && state_q == TFM_RUN) begin
                VCONN_EN_O <= 1'b1;
            end
        end
    end

    // advertised limit and status bit; no alert path touches the cable fault
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            MAX_CURRENT_O <= CURRENT_LIMIT_3A;
            STATUS_CABLE_LIMIT_O <= 1'b0;
        end else begin
            MAX_CURRENT_O <= CABLE_SUPPLY_OVERCURRENT_FAULT_FAULT_O ? CURRENT_LIMIT_3A : CURRENT_LIMIT_5A;
            STATUS_CABLE_LIMIT_O <= CABLE_SUPPLY_OVERCURRENT_FAULT_FAULT_O;
        end
    end
endmodule : tfm_monitor

// ==== rtl/tfm_pkg.sv ====
// package of constants for the thermal, config-channel and cable-supply fault monitor
package tfm_pkg;
    // clock rate in kHz, used to turn times into cycle counts
    localparam int unsigned CLK_KHZ = 40000;
    // debounce and restart times in microseconds (plain defaults, no printed figure)
    localparam int unsigned THERMAL_DEBOUNCE_US = 10000;
    localparam int unsigned CONFIG_CHANNEL_DEBOUNCE_US = 100;
    localparam int unsigned CABLE_SUPPLY_DEBOUNCE_US = 1000;
    localparam int unsigned AUTO_RESTART_US = 2000000;
    // cycle counts derived from the times, rounded up as least times
    localparam int unsigned THERMAL_DEBOUNCE_CYC = (THERMAL_DEBOUNCE_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned CONFIG_CHANNEL_DEBOUNCE_CYC = (CONFIG_CHANNEL_DEBOUNCE_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned CABLE_SUPPLY_DEBOUNCE_CYC = (CABLE_SUPPLY_DEBOUNCE_US * CLK_KHZ + 999) / 1000;
    localparam longint unsigned AUTO_RESTART_CYC = (64'(AUTO_RESTART_US) * CLK_KHZ + 999) / 1000;
    // advertised current limits in units of 10 mA
    localparam logic [8:0] CURRENT_LIMIT_3A = 9'h12c;
    localparam logic [8:0] CURRENT_LIMIT_5A = 9'h1f4;
    // restart voltage in units of 50 mV
    localparam logic [8:0] RESTART_VOLTAGE_5V = 9'h064;
    // protection state machine
    typedef enum logic [1:0] {
        TFM_RUN,
        TFM_FAULT,
        TFM_RESTART
    } tfm_prot_e;
endpackage : tfm_pkg

// ==== rtl/tfm_debounce.sv ====
// debounce counter: output rises only after an uninterrupted excursion
`timescale 1ns/1ps
module tfm_debounce #(
    parameter int unsigned COUNT = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cond_i,
    output logic hit_o
);
    localparam int unsigned W = $clog2(COUNT + 1);
    // the counter must cover at least one cycle
    if (COUNT < 1) begin : g_bad
        $error("tfm_debounce: COUNT must be at least 1");
    end
    logic [W-1:0] cnt_q;
    // count while held, restart on any drop-out
    always_ff @(posedge clk_i) begin
        if (rst_i || !cond_i) begin
            cnt_q <= '0;
            hit_o <= 1'b0;
        end else if (cnt_q != W'(COUNT)) begin
            cnt_q <= cnt_q + W'(1);
            hit_o <= (cnt_q == W'(COUNT - 1));
        end else begin
            hit_o <= 1'b1;
        end
    end
endmodule : tfm_debounce

// ==== bench/tfm_chk_monitor.sv ====
// checker for the fault monitor, bound to its top-level ports
`timescale 1ns/1ps
module tfm_chk #(
    parameter longint unsigned RESTART_CYC = 20
) (
    input wire logic CORE_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic THERMISTOR_PKG_I,
    input wire logic DIE_WARN_I,
    input wire logic DIE_OTP_I,
    input wire logic THERM_WARN_I,
    input wire logic THERM_OTP_I,
    input wire logic CC1_OVER_I,
    input wire logic CC2_OVER_I,
    input wire logic VCONN_OVER_I,
    input wire logic CONTRACT_DONE_I,
    input wire logic ALERT_WARN_O,
    input wire logic ALERT_OTP_O,
    input wire logic DIE_OTP_FAULT_O,
    input wire logic THERM_OTP_FAULT_O,
    input wire logic CONFIG_CHANNEL_OVERVOLTAGE_FAULT_FAULT_O,
    input wire logic CABLE_SUPPLY_OVERCURRENT_FAULT_FAULT_O,
    input wire logic CC_PULLUP_EN_O,
    input wire logic LOAD_SWITCH_EN_O,
    input wire logic RESTART_O,
    input wire logic [8:0] RESTART_VOLTAGE_O,
    input wire logic VCONN_EN_O,
    input wire logic DISCOVERY_ABORT_O,
    input wire logic [8:0] MAX_CURRENT_O,
    input wire logic STATUS_CABLE_LIMIT_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    wire any_fault = DIE_OTP_FAULT_O | THERM_OTP_FAULT_O | CONFIG_CHANNEL_OVERVOLTAGE_FAULT_FAULT_O; // faults that disconnect
    longint unsigned quiet_q; // cycles disconnected with no fault, i.e. the restart wait
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I || CC_PULLUP_EN_O || any_fault) begin
            quiet_q <= 0;
        end else begin
            quiet_q <= quiet_q + 1;
        end
    end
    sequence s_cable_cut; !VCONN_EN_O && DISCOVERY_ABORT_O; endsequence
    sequence s_limit_3a; MAX_CURRENT_O == 9'h12c && STATUS_CABLE_LIMIT_O; endsequence
    sequence s_reconnect; !RESTART_O && CC_PULLUP_EN_O && LOAD_SWITCH_EN_O; endsequence
    a_config_channel_overvoltage_fault_cause: assert property ($rose(CONFIG_CHANNEL_OVERVOLTAGE_FAULT_FAULT_O) |-> $past(CC1_OVER_I || CC2_OVER_I, 6))
        else $error("channel overvoltage fault without input");
    a_die_otp_cause: assert property ($rose(DIE_OTP_FAULT_O) |-> $past(DIE_OTP_I, 6))
        else $error("die fault without input");
    a_therm_otp_pkg: assert property ($rose(THERM_OTP_FAULT_O) |-> THERMISTOR_PKG_I && $past(THERM_OTP_I, 6))
        else $error("thermistor fault on wrong package or without input");
    a_warn_source: assert property ($rose(ALERT_WARN_O) |->
        (THERMISTOR_PKG_I ? $past(THERM_WARN_I, 6) : $past(DIE_WARN_I, 6)))
        else $error("warning alert from wrong source");
    a_fault_disconnect: assert property (any_fault |=> !CC_PULLUP_EN_O && !LOAD_SWITCH_EN_O)
        else $error("fault left sink connected");
    a_restart_wait: assert property (RESTART_O |-> quiet_q + 3 > RESTART_CYC)
        else $error("restart before delay");
    a_restart_reconnect: assert property (RESTART_O |-> RESTART_VOLTAGE_O == 9'h064 ##1 s_reconnect)
        else $error("restart not at 5 V or no reconnect");
    a_cable_abort: assert property ($rose(CABLE_SUPPLY_OVERCURRENT_FAULT_FAULT_O) |-> s_cable_cut ##1 s_limit_3a)
        else $error("cable overcurrent handling wrong");
    a_cable_cause: assert property ($rose(CABLE_SUPPLY_OVERCURRENT_FAULT_FAULT_O) |-> $past(VCONN_EN_O) && $past(VCONN_OVER_I, 6))
        else $error("cable fault without cause");
    a_cable_quiet: assert property ($rose(CABLE_SUPPLY_OVERCURRENT_FAULT_FAULT_O) && CC_PULLUP_EN_O && !any_fault |=>
        CC_PULLUP_EN_O && !$rose(ALERT_WARN_O) && !$rose(ALERT_OTP_O))
        else $error("cable fault broke messaging or raised alert");
    a_otp_history: assert property ($rose(ALERT_OTP_O) |-> $past(CONTRACT_DONE_I) || $past(CONTRACT_DONE_I, 2))
        else $error("history alert without contract");
endmodule : tfm_chk
bind tfm_monitor tfm_chk #(.RESTART_CYC(RESTART_CYC)) u_chk (.*);

// ==== bench/tfm_sink_model.sv ====
// model of the attached sink: attaches, makes contracts, takes alerts
`timescale 1ns/1ps
module tfm_sink_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic plug_i,
    input wire logic slow_i,
    input wire logic pullup_i,
    input wire logic alert_i,
    output logic attach_o = 1'b0,
    output logic contract_o = 1'b0,
    output logic taken_o = 1'b0
);
    logic [2:0] att_q = 3'h0; // cycles since attach, saturating
    logic [3:0] wait_q = 4'h0; // cycles an alert has waited
    // a real sink only sees the port while the pull-up is presented
    always @(posedge clk_i) begin
        attach_o <= !rst_i && plug_i && pullup_i;
        att_q <= (rst_i || !attach_o) ? 3'h0 : att_q + 3'(att_q != 3'h7);
        contract_o <= !rst_i && att_q == 3'h3;
    end
    // alerts are consumed after a short or a long delay
    always @(posedge clk_i) begin
        if (rst_i || !alert_i || taken_o) begin
            wait_q <= 4'h0;
            taken_o <= 1'b0;
        end else begin
            wait_q <= wait_q + 4'h1;
            taken_o <= wait_q == (slow_i ? 4'h9 : 4'h1);
        end
    end
endmodule : tfm_sink_model

// ==== bench/tfm_monitor_tb.sv ====
// self-checking bench for the fault monitor with a sink model
`timescale 1ns/1ps
module tfm_monitor_tb;
    import tfm_pkg::*;
    localparam int unsigned TD = 8; // shortened debounce and restart counts
    localparam int unsigned CD = 6;
    localparam int unsigned VD = 10;
    localparam longint unsigned RC = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pkg = 1'b0;
    logic slow = 1'b0;
    logic [6:0] cmp = 7'h0; // die warn, die otp, therm warn, therm otp, cc1, cc2, vconn
    logic attach, contract, taken, aw, ao, dof, tof, ccf, vcf, pu, ls, rs, ven, dab, stl;
    logic [8:0] rv, mc;
    logic [6:0] ev_q = 7'h0; // outputs seen at the previous check
    int mismatches = 0;
    int tests_run = 0;
    int seed = 32'ha2cf;
    int q[$]; // expected events, oldest first
    tfm_monitor #(.THERMAL_DEB_CYC(TD), .CC_DEB_CYC(CD), .VCONN_DEB_CYC(VD), .RESTART_CYC(RC)) dut (
        .CORE_CLK_I(clk), .SYS_RST_I(rst), .THERMISTOR_PKG_I(pkg), .DIE_WARN_I(cmp[0]), .DIE_OTP_I(cmp[1]),
        .THERM_WARN_I(cmp[2]), .THERM_OTP_I(cmp[3]), .CC1_OVER_I(cmp[4]), .CC2_OVER_I(cmp[5]),
        .VCONN_OVER_I(cmp[6]), .ATTACH_I(attach), .CONTRACT_DONE_I(contract), .ALERT_TAKEN_I(taken),
        .ALERT_WARN_O(aw), .ALERT_OTP_O(ao), .DIE_OTP_FAULT_O(dof), .THERM_OTP_FAULT_O(tof),
        .CONFIG_CHANNEL_OVERVOLTAGE_FAULT_FAULT_O(ccf), .CABLE_SUPPLY_OVERCURRENT_FAULT_FAULT_O(vcf), .CC_PULLUP_EN_O(pu), .LOAD_SWITCH_EN_O(ls),
        .RESTART_O(rs), .RESTART_VOLTAGE_O(rv), .VCONN_EN_O(ven), .DISCOVERY_ABORT_O(dab),
        .MAX_CURRENT_O(mc), .STATUS_CABLE_LIMIT_O(stl));
    tfm_sink_model sink (.clk_i(clk), .rst_i(rst), .plug_i(1'b1), .slow_i(slow), .pullup_i(pu),
        .alert_i(aw | ao), .attach_o(attach), .contract_o(contract), .taken_o(taken));
    initial forever #12.5 clk = ~clk;
    task automatic complete_run;
        $display("counts: tests_run=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run
    task automatic chk_val(input logic [8:0] got, input logic [8:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_ev(input int got, input int exp);
        tests_run++;
        if (got != exp) begin
            mismatches++;
            $display("ERROR %0t event %0d expected %0d", $time, got, exp);
        end
    endtask : chk_ev
    // inputs always move 1 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // bounded wait until every expected event has shown up
    task automatic drain;
        int i;
        for (i = 0; i < 300 && q.size() != 0; i++) tick(1);
        if (q.size() != 0) begin
            mismatches++;
            $display("ERROR %0t expected event missing", $time);
            complete_run();
        end
    endtask : drain
    task automatic do_reset(input logic strap);
        rst = 1'b1;
        pkg = strap;
        tick(12);
        rst = 1'b0;
        tick(4);
    endtask : do_reset
    // two interrupted excursions (random, then n - 1, one short) must stay silent, then a held one fires
    // gaps last two cycles: the input filter swallows a one-cycle drop, and n cycles already count as held
    task automatic fire(input int idx, input int code, input bit fault, input int n);
        int len;
        len = 1 + ({$random(seed)} % (n - 1));
        cmp[idx] = 1'b1;
        tick(len);
        cmp[idx] = 1'b0;
        tick(2);
        cmp[idx] = 1'b1;
        tick(n - 1);
        cmp[idx] = 1'b0;
        tick(2);
        q.push_back(code);
        cmp[idx] = 1'b1;
        drain();
        if (fault) begin
            tick(2);
            chk_val(9'({pu, ls}), 9'h0);
            q.push_back(6);
            if (code == 1 || code == 2) q.push_back(5);
        end
        cmp[idx] = 1'b0;
        drain();
        $display("test done: input %0d", idx);
    endtask : fire
    // watcher: each rising output takes the oldest note off the queue
    always @(negedge clk) begin
        logic [6:0] ev;
        ev = {rs, ao, aw, vcf, tof, dof, ccf};
        if (!rst) begin
            for (int b = 0; b < 7; b++) begin
                if (ev[b] && !ev_q[b]) begin
                    if (q.size() == 0) chk_ev(b, -1);
                    else chk_ev(b, q.pop_front());
                    if (b == 6) chk_val(rv, 9'h064);
                end
            end
        end
        ev_q = ev;
    end
    initial begin
        do_reset(1'b0);
        fire(4, 0, 1'b1, CD);
        slow = 1'b1;
        fire(5, 0, 1'b1, CD);
        fire(0, 4, 1'b0, TD);
        slow = 1'b0;
        fire(1, 1, 1'b1, TD);
        do_reset(1'b1);
        cmp[0] = 1'b1;
        tick(TD + 20);
        chk_val(9'(aw), 9'h0);
        $display("test done: die warning ignored on thermistor package");
        cmp[0] = 1'b0;
        fire(2, 4, 1'b0, TD);
        fire(3, 2, 1'b1, TD);
        fire(1, 1, 1'b1, TD);
        tick(10);
        chk_val(9'(ven), 9'h1);
        fire(6, 3, 1'b0, VD);
        chk_val(mc, 9'h12c);
        chk_val(9'({ven, pu, stl}), 9'h3);
        $display("test done: cable supply limit");
        // a fault cycle detaches the sink, which clears the cable latch for a fresh attempt
        fire(4, 0, 1'b1, CD);
        tick(6);
        chk_val(mc, 9'h1f4);
        chk_val(9'({ven, stl}), 9'h2);
        $display("test done: cable retried after detach");
        complete_run();
    end
endmodule : tfm_monitor_tb
